/* File: cmd_pulse_pkg.sv */
// types shared by the command pulse and mode block
package cmd_pulse_pkg;
  typedef enum logic [2:0] {
    MODE_POS = 3'h1,
    MODE_SPD = 3'h2,
    MODE_TRQ = 3'h4
  } run_mode_type;
  typedef enum logic [1:0] {
    SYS_INC       = 2'h0,
    SYS_ABS       = 2'h1,
    SYS_ABS_NOOVF = 2'h2
  } pos_system_type;
  typedef enum logic [1:0] {
    DIV_IDLE = 2'h1,
    DIV_RUN  = 2'h2
  } div_state_type;
endpackage

/* File: cmd_pulse_regs.svh */
// register offsets, field positions, reset values and limits
`ifndef CMD_PULSE_REGS_SVH
`define CMD_PULSE_REGS_SVH
`define OFF_CFG        8'h00
`define OFF_PPT        8'h04
`define OFF_GEAR_NUM   8'h08
`define OFF_GEAR_DEN   8'h0C
`define OFF_CTRL       8'h10
`define OFF_PRESET     8'h14
`define OFF_STATUS     8'h18
`define OFF_POS_LO     8'h1C
`define OFF_POS_TURNS  8'h20
`define OFF_INT_STAT   8'h24
`define OFF_INT_MASK   8'h28
`define CFG_MODE_LSB   0
`define CFG_SYS_LSB    4
`define CFG_FMT_LSB    8
`define CFG_DIR_BIT    12
`define CTRL_REINIT    0
`define CTRL_PRESET    1
`define INT_OVF_BIT    0
`define INT_MODE_BIT   1
`define CFG_RST        13'h0000
`define PPT_RST        21'h000000
`define GEAR_NUM_RST   23'h000010
`define GEAR_DEN_RST   23'h000001
`define PPT_MIN        21'h000040
`define PPT_MAX        21'h100000
`define GEAR_MAX       23'h400000
`define TURN_MIN       (-32767)
`define TURN_MAX       32766
`define MODE_COMBO_MAX 3'h5
`define FMT_OC_FIRST   3'h3
`endif

/* File: command_pulse_gear_mode.sv */
// control mode select, command pulse decode, gear scaling and position keeping
//
// Notes on behaviour
// R1: starred settings take effect only at power-on, later writes wait for it.
// R2: control mode 0..7 decodes to position, speed, torque, combos, extension, positioning.
// R3: combos 3..5 take first mode when select off, second when on, live.
// R4: position control follows the pulse train only in modes 0 to 5.
// R5: mode 6 starts in speed control at power-on.
// R6: mode 7 selects position control right after power-on.
// R7: position system 0 incremental, 1 absolute, 2 absolute without overflow check.
// R8: absolute mode alarms and stops outside -32767..+32766 turns.
// R9: system 2 never raises the overflow alarm.
// R10: overflow checked at power-on; a position preset clears the alarm.
// R11: format 0..2 differential, 3..5 open collector: pulse/sign, fwd/rev, A/B.
// R12: format, pulses per turn and gear matter only under position control.
// R13: decoder handles 500 kHz differential, 200 kHz open collector pulses.
// R14: A/B format counts every edge of both phases, four per period.
// R15: direction 0 maps forward to CCW, 1 maps forward to CW.
// R16: nonzero pulses per turn 64..1048576 sets pulses per turn; zero uses gear.
// R17: each pulse scaled by gear numerator over denominator, 1..4194304.
// R18: software should reduce the gear ratio to an integer up to 65535.
// R19: gear division remainder carries between pulses, no position lost.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "cmd_pulse_regs.svh"
module command_pulse_gear_mode #(
  parameter int ENC_BITS = 17,
  parameter int POS_W    = 48
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        diff_pulse_in,
  input  wire logic        diff_sign_in,
  input  wire logic        oc_pulse_in,
  input  wire logic        oc_sign_in,
  input  wire logic        mode_select_in,
  output logic             motor_step,
  output logic      [23:0] motor_step_count,
  output logic             motor_ccw,
  output logic      [2:0]  run_mode,
  output logic             multiturn_overflow_alarm,
  output logic             drive_stop,
  output logic             homing_needed,
  output logic             irq
);
  localparam int TW = POS_W - ENC_BITS;

  // pin synchronisers: diff pulse, diff sign, oc pulse, oc sign, mode select
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic [3:0] pin_prev_reg;
  // R13 two-flop sampling at 40 MHz resolves edges far above 500 kHz
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
      pin_prev_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {mode_select_in, oc_sign_in, oc_pulse_in, diff_sign_in, diff_pulse_in};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg[3:0];
    end
  end

  // software shadows of the settings
  logic [12:0] cfg_reg;
  logic [20:0] ppt_reg;
  logic [22:0] num_reg;
  logic [22:0] den_reg;
  logic [31:0] preset_reg;
  logic [1:0]  int_stat_reg;
  logic [1:0]  int_mask_reg;
  // power-on settings in force
  logic [2:0]  act_mode_reg;
  logic [1:0]  act_sys_reg;
  logic [2:0]  act_fmt_reg;
  logic        act_dir_reg;
  logic [20:0] act_ppt_reg;
  logic        por_pending_reg;
  logic        por_check_reg;

  logic apb_done;
  logic wr_en;
  logic do_reinit;
  logic do_preset;
  assign apb_done  = psel & penable & pready;
  assign wr_en     = apb_done & pwrite;
  assign do_reinit = wr_en & (paddr == `OFF_CTRL) & pwdata[`CTRL_REINIT];
  assign do_preset = wr_en & (paddr == `OFF_CTRL) & pwdata[`CTRL_PRESET];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cfg_reg      <= `CFG_RST;
      ppt_reg      <= `PPT_RST;
      num_reg      <= `GEAR_NUM_RST;
      den_reg      <= `GEAR_DEN_RST;
      preset_reg   <= 32'h00000000;
      int_mask_reg <= 2'h0;
    end else if (wr_en) begin
      unique case (paddr)
        `OFF_CFG:       cfg_reg <= pwdata[12:0];
        `OFF_PPT:
          // R16 only zero or 64..1048576 is stored
          if (pwdata[31:21] == 11'h000 && (pwdata[20:0] == 21'h000000
              || (pwdata[20:0] >= `PPT_MIN && pwdata[20:0] <= `PPT_MAX)))
            ppt_reg <= pwdata[20:0];
        `OFF_GEAR_NUM:
          if (pwdata != 32'h0 && pwdata <= 32'(`GEAR_MAX))
            num_reg <= pwdata[22:0];
        `OFF_GEAR_DEN:
          if (pwdata != 32'h0 && pwdata <= 32'(`GEAR_MAX))
            den_reg <= pwdata[22:0];
        `OFF_PRESET:    preset_reg <= pwdata;
        `OFF_INT_MASK:  int_mask_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // R1 latch on power-on or a soft power cycle; writes meanwhile stay pending
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      por_pending_reg <= 1'b1;
      por_check_reg   <= 1'b0;
      act_mode_reg    <= 3'h0;
      act_sys_reg     <= 2'h0;
      act_fmt_reg     <= 3'h0;
      act_dir_reg     <= 1'b0;
      act_ppt_reg     <= `PPT_RST;
    end else begin
      por_pending_reg <= do_reinit;
      por_check_reg   <= por_pending_reg;
      if (por_pending_reg) begin
        act_mode_reg <= cfg_reg[`CFG_MODE_LSB +: 3];
        act_sys_reg  <= cfg_reg[`CFG_SYS_LSB +: 2];
        act_fmt_reg  <= cfg_reg[`CFG_FMT_LSB +: 3];
        act_dir_reg  <= cfg_reg[`CFG_DIR_BIT];
        act_ppt_reg  <= ppt_reg;
      end
    end
  end

  // R2 R3 R5 R6 mode decode; select pin is live in combos 3 to 5
  cmd_pulse_pkg::run_mode_type mode_next;
  logic sel;
  assign sel = pin_sync_reg[4];
  always_comb begin
    unique case (act_mode_reg)
      3'h0: mode_next = cmd_pulse_pkg::MODE_POS;
      3'h1: mode_next = cmd_pulse_pkg::MODE_SPD;
      3'h2: mode_next = cmd_pulse_pkg::MODE_TRQ;
      3'h3: mode_next = sel ? cmd_pulse_pkg::MODE_SPD : cmd_pulse_pkg::MODE_POS;
      3'h4: mode_next = sel ? cmd_pulse_pkg::MODE_TRQ : cmd_pulse_pkg::MODE_POS;
      3'h5: mode_next = sel ? cmd_pulse_pkg::MODE_TRQ : cmd_pulse_pkg::MODE_SPD;
      3'h6: mode_next = cmd_pulse_pkg::MODE_SPD;
      3'h7: mode_next = cmd_pulse_pkg::MODE_POS;
    endcase
  end

  // R11 source and format split
  logic       use_oc;
  logic [2:0] form;
  logic       pa;
  logic       pb;
  logic       pa_old;
  logic       pb_old;
  assign use_oc = act_fmt_reg >= `FMT_OC_FIRST;
  assign form   = use_oc ? 3'(act_fmt_reg - `FMT_OC_FIRST) : act_fmt_reg;
  assign pa     = use_oc ? pin_sync_reg[2] : pin_sync_reg[0];
  assign pb     = use_oc ? pin_sync_reg[3] : pin_sync_reg[1];
  assign pa_old = use_oc ? pin_prev_reg[2] : pin_prev_reg[0];
  assign pb_old = use_oc ? pin_prev_reg[3] : pin_prev_reg[1];

  logic cnt_up;
  logic cnt_dn;
  logic pulse_ctl;
  // R4 R12 decoding and scaling only under pulse-driven position control
  assign pulse_ctl = (run_mode == cmd_pulse_pkg::MODE_POS)
                     && (act_mode_reg <= `MODE_COMBO_MAX) && !drive_stop;
  always_comb begin
    cnt_up = 1'b0;
    cnt_dn = 1'b0;
    if (form == 3'h0) begin
      // pulse and sign: sign low means forward
      cnt_up = pa & ~pa_old & ~pb;
      cnt_dn = pa & ~pa_old & pb;
    end else if (form == 3'h1) begin
      // forward and reverse trains; coincident edges cancel
      cnt_up = (pa & ~pa_old) & ~(pb & ~pb_old);
      cnt_dn = (pb & ~pb_old) & ~(pa & ~pa_old);
    end else if (form == 3'h2) begin
      // R14 every edge of either phase counts; a double step is dropped
      cnt_up = ((pa ^ pa_old) ^ (pb ^ pb_old)) & (pa ^ pb_old);
      cnt_dn = ((pa ^ pa_old) ^ (pb ^ pb_old)) & ~(pa ^ pb_old);
    end
    if (!pulse_ctl) begin
      cnt_up = 1'b0;
      cnt_dn = 1'b0;
    end
  end

  // R16 R17 effective ratio, divided once per change so each pulse costs one cycle
  logic [22:0] eff_num;
  logic [22:0] eff_den;
  assign eff_num = (act_ppt_reg != 21'h0) ? 23'(1 << ENC_BITS) : num_reg;
  assign eff_den = (act_ppt_reg != 21'h0) ? 23'(act_ppt_reg) : den_reg;

  cmd_pulse_pkg::div_state_type div_state_reg;
  logic [22:0] dv_num_reg;
  logic [22:0] dv_den_reg;
  logic [22:0] dv_quo_reg;
  logic [22:0] dv_rem_reg;
  logic [4:0]  dv_cnt_reg;
  logic [23:0] dv_trial;
  logic [22:0] gear_q_reg;
  logic [22:0] gear_r_reg;
  logic [22:0] gear_den_reg;
  logic        gear_new_reg;
  assign dv_trial = {dv_rem_reg, dv_quo_reg[22]};

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_state_reg <= cmd_pulse_pkg::DIV_IDLE;
      dv_num_reg    <= `GEAR_NUM_RST;
      dv_den_reg    <= `GEAR_DEN_RST;
      dv_quo_reg    <= 23'h000000;
      dv_rem_reg    <= 23'h000000;
      dv_cnt_reg    <= 5'h00;
      gear_q_reg    <= `GEAR_NUM_RST;
      gear_r_reg    <= 23'h000000;
      gear_den_reg  <= `GEAR_DEN_RST;
      gear_new_reg  <= 1'b0;
    end else begin
      gear_new_reg <= 1'b0;
      unique case (div_state_reg)
        cmd_pulse_pkg::DIV_IDLE:
          if (eff_num != dv_num_reg || eff_den != dv_den_reg) begin
            dv_num_reg    <= eff_num;
            dv_den_reg    <= eff_den;
            dv_quo_reg    <= eff_num;
            dv_rem_reg    <= 23'h000000;
            dv_cnt_reg    <= 5'h00;
            div_state_reg <= cmd_pulse_pkg::DIV_RUN;
          end
        cmd_pulse_pkg::DIV_RUN: begin
          if (dv_trial >= {1'b0, dv_den_reg}) begin
            dv_rem_reg <= 23'(dv_trial - {1'b0, dv_den_reg});
            dv_quo_reg <= {dv_quo_reg[21:0], 1'b1};
          end else begin
            dv_rem_reg <= dv_trial[22:0];
            dv_quo_reg <= {dv_quo_reg[21:0], 1'b0};
          end
          dv_cnt_reg <= 5'(dv_cnt_reg + 5'h01);
          if (dv_cnt_reg == 5'h16) begin
            div_state_reg <= cmd_pulse_pkg::DIV_IDLE;
            gear_new_reg  <= 1'b1;
          end
        end
      endcase
      if (gear_new_reg) begin
        // quotient and remainder switch together so no pulse sees a mixed ratio
        gear_q_reg   <= dv_quo_reg;
        gear_r_reg   <= dv_rem_reg;
        gear_den_reg <= dv_den_reg;
      end
    end
  end

  // R19 remainder carried between pulses in both directions
  logic [22:0] acc_reg;
  logic [23:0] acc_sum;
  logic [23:0] step_amt;
  logic [22:0] acc_next;
  always_comb begin
    acc_sum  = {1'b0, acc_reg} + {1'b0, gear_r_reg};
    step_amt = {1'b0, gear_q_reg};
    acc_next = acc_reg;
    if (cnt_up) begin
      if (acc_sum >= {1'b0, gear_den_reg}) begin
        acc_next = 23'(acc_sum - {1'b0, gear_den_reg});
        step_amt = 24'(step_amt + 24'h000001);
      end else begin
        acc_next = acc_sum[22:0];
      end
    end else if (cnt_dn) begin
      if (acc_reg < gear_r_reg) begin
        acc_next = 23'(acc_reg + gear_den_reg - gear_r_reg);
        step_amt = 24'(step_amt + 24'h000001);
      end else begin
        acc_next = 23'(acc_reg - gear_r_reg);
      end
    end
  end

  logic signed [POS_W-1:0] pos_reg;
  logic signed [TW-1:0]    turns;
  logic                    turn_ovf;
  assign turns    = pos_reg[POS_W-1:ENC_BITS];
  assign turn_ovf = (turns < TW'(`TURN_MIN)) || (turns > TW'(`TURN_MAX));

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      acc_reg          <= 23'h000000;
      pos_reg          <= '0;
      motor_step       <= 1'b0;
      motor_step_count <= 24'h000000;
      motor_ccw        <= 1'b0;
    end else begin
      motor_step <= cnt_up | cnt_dn;
      if (gear_new_reg) begin
        acc_reg <= 23'h000000;
      end else begin
        acc_reg <= acc_next;
      end
      if (cnt_up | cnt_dn) begin
        motor_step_count <= step_amt;
        // R15 forward is CCW unless the direction setting is 1
        motor_ccw <= cnt_up ^ act_dir_reg;
      end
      if (do_preset) begin
        // R10 preset loads the position and clears the alarm below
        pos_reg <= POS_W'(signed'(preset_reg));
      end else if (por_pending_reg && cfg_reg[`CFG_SYS_LSB +: 2] == cmd_pulse_pkg::SYS_INC) begin
        // R7 incremental position does not survive a power cycle
        pos_reg <= '0;
      end else if (cnt_up) begin
        pos_reg <= pos_reg + POS_W'(step_amt);
      end else if (cnt_dn) begin
        pos_reg <= pos_reg - POS_W'(step_amt);
      end
    end
  end

  // alarm, stop, homing flag and mode register
  logic ovf_set;
  // R8 R9 R10 absolute only, at power-on and in operation
  assign ovf_set = (act_sys_reg == cmd_pulse_pkg::SYS_ABS) && turn_ovf
                   && !por_pending_reg && !do_preset;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      multiturn_overflow_alarm <= 1'b0;
      drive_stop               <= 1'b0;
      homing_needed            <= 1'b0;
      run_mode                 <= cmd_pulse_pkg::MODE_POS;
    end else begin
      if (ovf_set) begin
        multiturn_overflow_alarm <= 1'b1;
        drive_stop               <= 1'b1;
      end else if (do_preset || act_sys_reg == cmd_pulse_pkg::SYS_ABS_NOOVF) begin
        multiturn_overflow_alarm <= 1'b0;
        drive_stop               <= 1'b0;
      end
      // R7 incremental start needs homing; preset stands in for it
      if (por_check_reg && act_sys_reg == cmd_pulse_pkg::SYS_INC) begin
        homing_needed <= 1'b1;
      end else if (do_preset) begin
        homing_needed <= 1'b0;
      end
      run_mode <= mode_next;
    end
  end

  // sticky events, write one to clear, set beats clear
  logic [1:0] ev;
  assign ev[`INT_OVF_BIT]  = ovf_set & ~multiturn_overflow_alarm;
  assign ev[`INT_MODE_BIT] = (mode_next != run_mode) & ~por_check_reg;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      int_stat_reg <= 2'h0;
      irq          <= 1'b0;
    end else begin
      if (wr_en && paddr == `OFF_INT_STAT) begin
        int_stat_reg <= (int_stat_reg & ~pwdata[1:0]) | ev;
      end else begin
        int_stat_reg <= int_stat_reg | ev;
      end
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  // APB: one wait state, read data captured in the first access cycle
  logic [31:0] rd_mux;
  logic        rd_bad;
  always_comb begin
    rd_bad = 1'b0;
    unique case (paddr)
      `OFF_CFG:       rd_mux = {19'h0, cfg_reg};
      `OFF_PPT:       rd_mux = {11'h0, ppt_reg};
      `OFF_GEAR_NUM:  rd_mux = {9'h0, num_reg};
      `OFF_GEAR_DEN:  rd_mux = {9'h0, den_reg};
      `OFF_CTRL:      rd_mux = 32'h00000000;
      `OFF_PRESET:    rd_mux = preset_reg;
      `OFF_STATUS:    rd_mux = {14'h0, homing_needed, multiturn_overflow_alarm, run_mode,
                                act_dir_reg, 1'b0, act_fmt_reg, 2'h0, act_sys_reg,
                                1'b0, act_mode_reg};
      `OFF_POS_LO:    rd_mux = pos_reg[31:0];
      `OFF_POS_TURNS: rd_mux = 32'(turns);
      `OFF_INT_STAT:  rd_mux = {30'h0, int_stat_reg};
      `OFF_INT_MASK:  rd_mux = {30'h0, int_mask_reg};
      default: begin
        rd_mux = 32'h00000000;
        rd_bad = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rd_bad;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end
endmodule

/* File: command_pulse_gear_mode_asserts.sv */
// concurrent checks on the command pulse block ports
`timescale 1ns/1ps
module command_pulse_gear_mode_asserts (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        motor_step,
  input wire logic [2:0]  run_mode,
  input wire logic        multiturn_overflow_alarm,
  input wire logic        drive_stop,
  input wire logic        irq
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not two cycles");
  pready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_read_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
  stop_alarm_a: assert property (drive_stop == multiturn_overflow_alarm)
    else $error("stop differs from alarm");
  step_gate_a: assert property (motor_step |-> run_mode == 3'h1 && !multiturn_overflow_alarm)
    else $error("step outside position control");
  step_single_a: assert property (motor_step |=> !motor_step)
    else $error("step longer than one cycle");
  mode_hot_a: assert property ($onehot(run_mode))
    else $error("run mode not one-hot");
  reset_out_a: assert property (disable iff (1'b0) !nrst |=> run_mode == 3'h1 && !motor_step && !irq && !multiturn_overflow_alarm)
    else $error("outputs wrong after reset");
  cover property (motor_step);
  cover property ($rose(multiturn_overflow_alarm));
  cover property (pslverr);
endmodule
bind command_pulse_gear_mode command_pulse_gear_mode_asserts command_pulse_gear_mode_asserts_inst (
  .sys_clk, .nrst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .motor_step,
  .run_mode, .multiturn_overflow_alarm, .drive_stop, .irq);

/* File: pulse_host.sv */
// host pulse train generator for the command pulse pins
`timescale 1ns/1ps
module pulse_host (
  input  wire logic sys_clk,
  output logic      diff_pulse_in,
  output logic      diff_sign_in,
  output logic      oc_pulse_in,
  output logic      oc_sign_in
);
  initial begin
    {diff_pulse_in, diff_sign_in} = 2'h0;
    {oc_pulse_in, oc_sign_in} = 2'h0;
  end
  task automatic drive(input logic oc, input logic [1:0] v, input int half);
    @(posedge sys_clk);
    if (oc) begin
      {oc_pulse_in, oc_sign_in} <= v;
    end else begin
      {diff_pulse_in, diff_sign_in} <= v;
    end
    repeat (half - 1) @(posedge sys_clk);
  endtask
  // n is pulses for kinds 0 and 1, quadrature periods for kind 2
  task automatic send(input logic oc, input logic [1:0] kind, input logic fwd, input int n);
    int         half;
    logic       a;
    logic       b;
    logic [1:0] v;
    // each level held half a period of the top rate
    half = oc ? 100 : 40;
    // sign settles before the first pulse edge
    if (kind == 2'h0) drive(oc, {1'b0, !fwd}, half);
    for (int k = 0; k < n * (kind == 2'h2 ? 4 : 2); k++) begin
      a = k % 4 < 2;
      b = k % 4 == 1 || k % 4 == 2;
      // pulse and sign, two pulse lines, quadrature
      case (kind)
        2'h0: v = {~k[0], !fwd};
        2'h1: v = {fwd & ~k[0], !fwd & ~k[0]};
        default: v = fwd ? {a, b} : {b, a};
      endcase
      drive(oc, v, half);
    end
    drive(oc, 2'h0, half);
  endtask
endmodule

/* File: test_command_pulse_gear_mode.sv */
// self-checking bench for the command pulse, gear and mode block
`timescale 1ns/1ps
`include "cmd_pulse_regs.svh"
module test_command_pulse_gear_mode;
  // run_mode per control mode, three bits each, select off and on
  localparam logic [23:0] mode_off_tbl = 24'h291311;
  localparam logic [23:0] mode_on_tbl  = 24'h2A4511;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        mode_select_in = 1'b0;
  logic        diff_pulse_in, diff_sign_in, oc_pulse_in, oc_sign_in;
  logic [31:0] prdata;
  logic        pready, pslverr, motor_step, motor_ccw, irq;
  logic [23:0] motor_step_count;
  logic [2:0]  run_mode;
  logic        multiturn_overflow_alarm, drive_stop, homing_needed;
  int          n_fail = 0;
  int          checked = 0;
  int          steps = 0;
  int          s0 = 0;
  logic [31:0] sum = 32'h0;
  logic [31:0] m0;
  logic [31:0] q;
  logic        er;
  command_pulse_gear_mode command_pulse_gear_mode_inst (.sys_clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .diff_pulse_in, .diff_sign_in,
    .oc_pulse_in, .oc_sign_in, .mode_select_in, .motor_step, .motor_step_count, .motor_ccw,
    .run_mode, .multiturn_overflow_alarm, .drive_stop, .homing_needed, .irq);
  pulse_host pulse_host_inst (.sys_clk, .diff_pulse_in, .diff_sign_in, .oc_pulse_in,
    .oc_sign_in);
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (motor_step === 1'b1) begin
      steps++;
      sum += motor_step_count;
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check("prdata", q, e);
  endtask
  // settings only reach the active set through a soft power cycle
  task automatic pc(input logic [31:0] cfg);
    wr(`OFF_CFG, cfg);
    wr(`OFF_CTRL, 32'h1);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic go(input logic oc, input logic [1:0] k, input logic f, input int n);
    s0 = steps;
    m0 = sum;
    pulse_host_inst.send(oc, k, f, n);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic pulses(input int n, input logic [31:0] total);
    check("steps", steps - s0, n);
    check("step sum", sum - m0, total);
  endtask
  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    results();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check("homing", homing_needed, 1'b1);
    rd(`OFF_GEAR_NUM, 32'h10);
    rd(`OFF_GEAR_DEN, 32'h1);
    wr(`OFF_GEAR_NUM, 32'h0);
    rd(`OFF_GEAR_NUM, 32'h10);
    wr(`OFF_PPT, 32'h3F);
    rd(`OFF_PPT, 32'h0);
    rd(8'h2C, 32'h0);
    check("pslverr", er, 1'b1);
    wr(`OFF_CFG, 32'h1200);
    go(1'b0, 2'h0, 1'b1, 1);
    pulses(1, 16);
    check("ccw", motor_ccw, 1'b1);
    for (int f = 0; f < 6; f++) begin
      pc({f[1], 1'b0, f[2:0], 8'h00});
      go(f > 2, 2'(f % 3), f[0], 2);
      pulses(f % 3 == 2 ? 8 : 2, f % 3 == 2 ? 128 : 32);
      check("ccw", motor_ccw, f[0] ^ f[1]);
    end
    pc(32'h0);
    wr(`OFF_GEAR_NUM, 32'h3);
    wr(`OFF_GEAR_DEN, 32'h2);
    repeat (60) @(posedge sys_clk);
    go(1'b0, 2'h0, 1'b1, 4);
    pulses(4, 6);
    wr(`OFF_PPT, 32'h10000);
    // pulses per turn is a power-on setting, so it needs a soft power cycle
    pc(32'h0);
    repeat (60) @(posedge sys_clk);
    go(1'b0, 2'h0, 1'b1, 3);
    pulses(3, 6);
    wr(`OFF_PPT, 32'h0);
    wr(`OFF_INT_MASK, 32'h2);
    for (int m = 0; m < 8; m++) begin
      pc(m);
      for (int s = 0; s < 2; s++) begin
        mode_select_in <= s[0];
        repeat (6) @(posedge sys_clk);
        check("run_mode", run_mode, 3'((s ? mode_on_tbl : mode_off_tbl) >> 3 * m));
      end
    end
    mode_select_in <= 1'b0;
    check("irq", irq, 1'b1);
    wr(`OFF_INT_STAT, 32'h3);
    wr(`OFF_INT_MASK, 32'h0);
    check("irq", irq, 1'b0);
    pc(32'h3);
    mode_select_in <= 1'b1;
    go(1'b0, 2'h0, 1'b1, 2);
    pulses(0, 0);
    check("irq", irq, 1'b0);
    rd(`OFF_INT_STAT, 32'h2);
    mode_select_in <= 1'b0;
    pc(32'h0210);
    wr(`OFF_GEAR_NUM, 32'h400000);
    wr(`OFF_GEAR_DEN, 32'h1);
    repeat (60) @(posedge sys_clk);
    wr(`OFF_PRESET, 32'h7FFFFFFF);
    wr(`OFF_CTRL, 32'h2);
    go(1'b0, 2'h2, 1'b1, 128);
    pulses(512, 32'h80000000);
    check("alarm", multiturn_overflow_alarm, 1'b1);
    check("stop", drive_stop, 1'b1);
    rd(`OFF_POS_TURNS, 32'h7FFF);
    go(1'b0, 2'h2, 1'b1, 1);
    pulses(0, 0);
    pc(32'h0220);
    check("alarm", multiturn_overflow_alarm, 1'b0);
    pc(32'h0210);
    check("alarm", multiturn_overflow_alarm, 1'b1);
    wr(`OFF_PRESET, 32'h0);
    wr(`OFF_CTRL, 32'h2);
    repeat (4) @(posedge sys_clk);
    check("alarm", multiturn_overflow_alarm, 1'b0);
    check("homing", homing_needed, 1'b0);
    rd(`OFF_STATUS, 32'h2210);
    results();
  end
endmodule
